// ### rtl/flash_host_pkg.sv
package flash_host_pkg;

  // Parallel bus widths
  localparam int ADDR_W = 22;
  localparam int DQ_W = 16;

  // Command bytes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ID = 8'h90;

  // Status word layout
  localparam int STATUS_READY_BIT = 7;

  // Bus timing in ns and in mclk cycles (least times round up)
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_SETUP_NS = 10;
  localparam int T_STROBE_NS = 50;
  localparam int T_ACCESS_NS = 70;
  localparam int T_HOLD_NS = 10;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] SETUP_CYC =
    CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STROBE_CYC =
    CNT_W'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACCESS_CYC =
    CNT_W'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC =
    CNT_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // User operations
  typedef enum logic [2:0] {
    op_read_array,
    op_read_status,
    op_read_id,
    op_program,
    op_erase,
    op_resume,
    op_clear_status
  } op_t;

  // First command byte of each operation, placed on the data bus
  function automatic logic [DQ_W-1:0] cmd_word(input logic [7:0] code);
    cmd_word = {{(DQ_W-8){1'b0}}, code};
  endfunction : cmd_word

  function automatic logic [7:0] op_code(input op_t op);
    case (op)
      op_read_array: op_code = CMD_READ_ARRAY;
      op_read_status: op_code = CMD_READ_STATUS;
      op_read_id: op_code = CMD_READ_ID;
      op_program: op_code = CMD_PROG_SETUP;
      op_erase: op_code = CMD_ERASE_SETUP;
      op_resume: op_code = CMD_CONFIRM;
      op_clear_status: op_code = CMD_CLEAR_STATUS;
      default: op_code = CMD_READ_ARRAY;
    endcase
  endfunction : op_code

endpackage : flash_host_pkg

// ### rtl/flash_bus_cycle.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module flash_bus_cycle
  import flash_host_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Cycle request
  input wire logic start,
  input wire logic write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] wdata,
  output logic ready,
  output logic done,
  output logic [DQ_W-1:0] rdata,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DQ_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [DQ_W-1:0] flash_dq_in
);

  typedef enum logic [1:0] {b_idle, b_setup, b_strobe, b_hold} bus_state_t;

  bus_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic is_write, next_is_write;
  logic next_ce_n, next_we_n, next_oe_n, next_dq_oe;
  logic [ADDR_W-1:0] next_addr;
  logic [DQ_W-1:0] next_dq_out, next_rdata;

  assign ready = (state == b_idle);
  assign done = (state == b_hold) && (cnt == CNT_ONE);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_is_write = is_write;
    next_ce_n = flash_ce_n;
    next_we_n = flash_we_n;
    next_oe_n = flash_oe_n;
    next_dq_oe = flash_dq_oe;
    next_addr = flash_addr;
    next_dq_out = flash_dq_out;
    next_rdata = rdata;
    case (state)
      b_idle: begin
        if (start) begin
          next_state = b_setup;
          next_cnt = SETUP_CYC;
          next_is_write = write;
          next_ce_n = 1'b0;
          next_addr = addr;
          next_dq_out = wdata;
          next_dq_oe = write;
        end
      end
      b_setup: begin
        if (cnt == CNT_ONE) begin
          next_state = b_strobe;
          next_cnt = is_write ? STROBE_CYC : ACCESS_CYC;
          next_we_n = !is_write;
          next_oe_n = is_write;
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      b_strobe: begin
        if (cnt == CNT_ONE) begin
          // Device latches on the rising strobe; data stays driven in hold
          next_state = b_hold;
          next_cnt = HOLD_CYC;
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          if (!is_write) begin
            next_rdata = flash_dq_in;
          end
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      b_hold: begin
        if (cnt == CNT_ONE) begin
          next_state = b_idle;
          next_ce_n = 1'b1;
          next_dq_oe = 1'b0;
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      default: next_state = b_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= b_idle;
      cnt <= '0;
      is_write <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_dq_oe <= 1'b0;
      flash_addr <= '0;
      flash_dq_out <= '0;
      rdata <= '0;
    end else if (clk_en) begin
      state <= next_state;
      cnt <= next_cnt;
      is_write <= next_is_write;
      flash_ce_n <= next_ce_n;
      flash_we_n <= next_we_n;
      flash_oe_n <= next_oe_n;
      flash_dq_oe <= next_dq_oe;
      flash_addr <= next_addr;
      flash_dq_out <= next_dq_out;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_strobe_data_held: assert property (@(posedge mclk) disable iff (reset)
    $rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n)
    else $error("write data not held at end of strobe");

endmodule : flash_bus_cycle

// ### rtl/flash_host.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module flash_host
  import flash_host_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DQ_W-1:0] req_data,
  input wire logic suspend_req,
  // User response
  output logic resp_valid,
  output logic [DQ_W-1:0] resp_data,
  output logic resp_suspended,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DQ_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [DQ_W-1:0] flash_dq_in
);

  typedef enum logic [2:0] {
    st_idle, st_cmd, st_data, st_read, st_poll, st_suspend, st_done
  } host_state_t;

  host_state_t state, next_state;
  op_t op, next_op;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DQ_W-1:0] data, next_data;
  logic [DQ_W-1:0] next_resp_data;
  logic next_resp_suspended;
  logic susp_pend, next_susp_pend;

  logic bus_start, bus_write, bus_ready, bus_done;
  logic [DQ_W-1:0] bus_wdata, bus_rdata;
  logic [ADDR_W-1:0] bus_addr;
  logic waiting_busy;

  ////////////////////////////////////////////////////////////////////////////
  flash_bus_cycle u_bus (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .start(bus_start),
    .write(bus_write),
    .addr(bus_addr),
    .wdata(bus_wdata),
    .ready(bus_ready),
    .done(bus_done),
    .rdata(bus_rdata),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign req_ready = (state == st_idle) && clk_en;
  assign resp_valid = (state == st_done);
  assign waiting_busy = (state == st_poll)
    && ((op == op_program) || (op == op_erase) || (op == op_resume));

  // Bus request for the current state
  always_comb begin
    bus_start = 1'b0;
    bus_write = 1'b0;
    bus_addr = addr;
    bus_wdata = '0;
    case (state)
      st_cmd: begin
        bus_start = bus_ready && clk_en;
        bus_write = 1'b1;
        bus_wdata = cmd_word(op_code(op));
      end
      st_data: begin
        bus_start = bus_ready && clk_en;
        bus_write = 1'b1;
        bus_wdata = (op == op_erase) ? cmd_word(CMD_CONFIRM) : data;
      end
      st_suspend: begin
        bus_start = bus_ready && clk_en;
        bus_write = 1'b1;
        bus_wdata = cmd_word(CMD_SUSPEND);
      end
      st_read, st_poll: begin
        bus_start = bus_ready && clk_en;
      end
      default: bus_start = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_data = data;
    next_resp_data = resp_data;
    next_resp_suspended = resp_suspended;
    next_susp_pend = susp_pend;
    // Suspend request set wins over its clear; one B0H per operation
    if (suspend_req && waiting_busy && !resp_suspended) begin
      next_susp_pend = 1'b1;
    end else if (state == st_suspend && bus_done) begin
      next_susp_pend = 1'b0;
    end
    case (state)
      st_idle: begin
        next_susp_pend = 1'b0;
        if (req_valid) begin
          next_state = st_cmd;
          next_op = req_op;
          next_addr = req_addr;
          next_data = req_data;
          next_resp_suspended = 1'b0;
        end
      end
      st_cmd: begin
        if (bus_done) begin
          case (op)
            op_program, op_erase: next_state = st_data;
            op_resume: next_state = st_poll;
            op_clear_status: next_state = st_done;
            default: next_state = st_read;
          endcase
        end
      end
      st_data: begin
        if (bus_done) begin
          next_state = st_poll;
        end
      end
      st_read: begin
        if (bus_done) begin
          next_resp_data = bus_rdata;
          next_state = st_done;
        end
      end
      st_poll: begin
        if (bus_done) begin
          next_resp_data = bus_rdata;
          if (next_susp_pend) begin
            next_state = st_suspend;
          end else if (bus_rdata[STATUS_READY_BIT]) begin
            next_state = st_done;
          end
        end
      end
      st_suspend: begin
        if (bus_done) begin
          next_resp_suspended = 1'b1;
          next_state = st_poll;
        end
      end
      st_done: next_state = st_idle;
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= st_idle;
      op <= op_read_array;
      addr <= '0;
      data <= '0;
      resp_data <= '0;
      resp_suspended <= 1'b0;
      susp_pend <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      data <= next_data;
      resp_data <= next_resp_data;
      resp_suspended <= next_resp_suspended;
      susp_pend <= next_susp_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_read_array_cmd: assert property (
    @(posedge mclk) disable iff (reset)
    (bus_start && state == st_cmd && op == op_read_array)
      |-> bus_write && bus_wdata == cmd_word(CMD_READ_ARRAY))
    else $error("read array not preceded by FFH");

  chk_read_status_cmd: assert property (
    @(posedge mclk) disable iff (reset)
    (state == st_read && $past(state) == st_cmd && op == op_read_status)
      |-> $past(bus_wdata) == cmd_word(CMD_READ_STATUS))
    else $error("status read not preceded by 70H");

  chk_read_id_cmd: assert property (
    @(posedge mclk) disable iff (reset)
    (bus_start && state == st_cmd && op == op_read_id)
      |-> bus_wdata == cmd_word(CMD_READ_ID))
    else $error("identifier read not preceded by 90H");

  chk_program_data: assert property (
    @(posedge mclk) disable iff (reset)
    (bus_start && state == st_data && op == op_program)
      |-> bus_write && bus_wdata == data)
    else $error("program data not written after setup");

  chk_erase_confirm: assert property (
    @(posedge mclk) disable iff (reset)
    (bus_done && state == st_cmd && op == op_erase && clk_en)
      |=> state == st_data
      ##0 (!bus_start || bus_wdata == cmd_word(CMD_CONFIRM)))
    else $error("erase setup not followed by D0H");

  chk_single_suspend: assert property (
    @(posedge mclk) disable iff (reset)
    (bus_start && state == st_suspend) |-> !resp_suspended)
    else $error("suspend issued twice in one operation");

  chk_done_ready: assert property (
    @(posedge mclk) disable iff (reset)
    (resp_valid && (op == op_program || op == op_erase) && !resp_suspended)
      |-> resp_data[STATUS_READY_BIT])
    else $error("operation finished while status busy");

  chk_poll_reads_only: assert property (
    @(posedge mclk) disable iff (reset)
    (bus_start && state == st_poll) |-> !bus_write)
    else $error("write issued while polling busy flash");

  cov_program: cover property (@(posedge mclk) disable iff (reset)
    resp_valid && op == op_program);
  cov_erase: cover property (@(posedge mclk) disable iff (reset)
    resp_valid && op == op_erase);
  cov_suspend: cover property (@(posedge mclk) disable iff (reset)
    resp_valid && resp_suspended);
  cov_read_id: cover property (@(posedge mclk) disable iff (reset)
    resp_valid && op == op_read_id);

endmodule : flash_host

// ### bench/flash_model.sv
`timescale 1ns/1ps
///////////////////////////////////////////////////////////////////////////////
module flash_model
  import flash_host_pkg::*;
#(
  parameter int BUSY_CYC = 200,
  // Arbitrary identifier value
  parameter logic [DQ_W-1:0] ID_WORD = 16'h5A3C
)
(
  // Timer clock
  input wire logic mclk,
  // Flash pins
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [DQ_W-1:0] dq_in
);
  typedef enum logic [3:0] {
    s_ra, s_rs, s_rid, s_pset, s_prog, s_pss, s_psa, s_psid,
    s_eset, s_eerr, s_ers, s_ess, s_esa, s_esid
  } mstate_t;
  mstate_t st;
  logic [DQ_W-1:0] mem [16];
  logic [DQ_W-1:0] op_data;
  logic [DQ_W-1:0] rd;
  logic [DQ_W-1:0] last_q;
  logic [3:0] op_addr;
  logic rdy;
  logic drv;
  int busy_left;

  initial begin
    st = s_ra;
    busy_left = 0;
    last_q = '0;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'h1000 + DQ_W'(i);
    end
  end

  task automatic take(input logic [7:0] c);
    case (st)
      s_pset: begin
        op_addr = addr[3:0];
        op_data = dq_out;
        busy_left = BUSY_CYC;
        st = s_prog;
      end
      s_prog: if (c == CMD_SUSPEND) st = s_pss;
      s_ers: if (c == CMD_SUSPEND) st = s_ess;
      s_eset: begin
        busy_left = BUSY_CYC;
        st = (c == CMD_CONFIRM) ? s_ers : s_eerr;
      end
      s_pss, s_psa, s_psid: begin
        case (c)
          CMD_CONFIRM: st = s_prog;
          CMD_READ_STATUS, CMD_PROG_SETUP, 8'h10, CMD_ERASE_SETUP: st = s_pss;
          CMD_READ_ID: st = s_psid;
          default: st = s_psa;
        endcase
      end
      s_ess, s_esa, s_esid: begin
        case (c)
          CMD_CONFIRM: st = s_ers;
          CMD_READ_STATUS: st = s_ess;
          CMD_READ_ID: st = s_esid;
          CMD_PROG_SETUP, 8'h10: st = s_pset;
          default: st = s_esa;
        endcase
      end
      default: begin
        case (c)
          CMD_PROG_SETUP, 8'h10: st = s_pset;
          CMD_ERASE_SETUP: st = s_eset;
          CMD_READ_STATUS: st = s_rs;
          CMD_READ_ID: st = s_rid;
          CMD_CONFIRM: st = st;
          default: st = s_ra;
        endcase
      end
    endcase
  endtask : take

  always @(posedge we_n) begin
    if (ce_n === 1'b0) take(dq_out[7:0]);
  end

  // completion after busy time, off the host's edge
  always @(negedge mclk) begin
    if (st == s_prog || st == s_ers) begin
      if (busy_left > 1) begin
        busy_left--;
      end else begin
        if (st == s_prog) mem[op_addr] = op_data;
        else for (int i = 0; i < 16; i++) mem[i] = '1;
        st = s_rs;
      end
    end
  end

  always @* begin
    rdy = !(st == s_prog || st == s_ers);
    case (st)
      s_ra, s_psa, s_esa: rd = mem[addr[3:0]];
      s_rid, s_psid, s_esid: rd = ID_WORD;
      default: rd = DQ_W'(rdy) << STATUS_READY_BIT;
    endcase
  end

  // Released bus shows the inverse of the last value
  assign drv = (ce_n === 1'b0) && (oe_n === 1'b0) && (dq_oe !== 1'b1);
  assign dq_in = drv ? rd : ~last_q;
  always @(posedge mclk) begin
    if (drv) last_q <= rd;
  end
endmodule : flash_model

// ### bench/tb_top.sv
`timescale 1ns/1ps
///////////////////////////////////////////////////////////////////////////////
module tb_top;
  import flash_host_pkg::*;
  localparam int BUSY = 200;
  localparam logic [DQ_W-1:0] ID_W = 16'h5A3C;
  logic mclk, reset, clk_en, req_valid, req_ready, suspend_req;
  logic resp_valid, resp_suspended, ce_n, we_n, oe_n, dq_oe;
  op_t req_op;
  logic [ADDR_W-1:0] req_addr, f_addr;
  logic [DQ_W-1:0] req_data, resp_data, dq_out, dq_in, q;
  logic sq;
  realtime t0;
  int n_errors = 0;
  int compares = 0;

  flash_host u_dut (.mclk(mclk), .reset(reset), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .suspend_req(suspend_req),
    .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_suspended(resp_suspended), .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .flash_addr(f_addr), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
  flash_model #(.BUSY_CYC(BUSY), .ID_WORD(ID_W)) u_flash (.mclk(mclk),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(f_addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic test_done();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic check(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp,
                       input string msg);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic give_up();
    n_errors++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    test_done();
  endtask : give_up

  // One request through the handshake, then its response
  task automatic run_op(input op_t op, input logic [ADDR_W-1:0] a,
                        input logic [DQ_W-1:0] d, input logic s);
    logic ok;
    ok = 1'b0;
    req_op = op;
    req_addr = a;
    req_data = d;
    suspend_req = s;
    req_valid = 1'b1;
    t0 = $realtime;
    for (int i = 0; i < 50 && !ok; i++) begin
      ok = (req_ready === 1'b1);
      @(posedge mclk);
      #1;
    end
    req_valid = 1'b0;
    if (!ok) give_up();
    ok = 1'b0;
    for (int i = 0; i < 8000 && !ok; i++) begin
      if (resp_valid === 1'b1) ok = 1'b1;
      else begin
        @(posedge mclk);
        #1;
      end
    end
    if (!ok) give_up();
    suspend_req = 1'b0;
    q = resp_data;
    sq = resp_suspended;
    @(posedge mclk);
    #1;
    check(DQ_W'(ce_n), DQ_W'(1'b1), "chip select released");
    check(DQ_W'(dq_oe), DQ_W'(1'b0), "data bus released");
  endtask : run_op

  task automatic t_reads();
    run_op(op_read_array, 22'h000005, 16'h0000, 1'b0);
    check(q, 16'h1005, "array read after reset");
    run_op(op_read_status, 22'h000000, 16'h0000, 1'b0);
    check(q, 16'h0080, "status read");
    run_op(op_read_id, 22'h000000, 16'h0000, 1'b0);
    check(q, ID_W, "identifier read");
    run_op(op_clear_status, 22'h000000, 16'h0000, 1'b0);
    run_op(op_read_array, 22'h000002, 16'h0000, 1'b0);
    check(q, 16'h1002, "array read after clear");
    $display("test reads done");
  endtask : t_reads

  task automatic t_program();
    run_op(op_program, 22'h000003, 16'hA5C3, 1'b0);
    check(DQ_W'(q[STATUS_READY_BIT]), DQ_W'(1'b1), "ready after program");
    check(DQ_W'(sq), DQ_W'(1'b0), "no suspend flagged");
    check(DQ_W'($realtime - t0 >= BUSY * 5.0), 16'h0001, "poll");
    run_op(op_read_array, 22'h000003, 16'h0000, 1'b0);
    check(q, 16'hA5C3, "programmed word");
    $display("test program done");
  endtask : t_program

  task automatic t_prog_susp();
    run_op(op_program, 22'h000007, 16'h1234, 1'b1);
    check(DQ_W'(sq), DQ_W'(1'b1), "program suspended");
    check(DQ_W'(q[STATUS_READY_BIT]), DQ_W'(1'b1), "ready in suspend");
    check(DQ_W'($realtime - t0 < BUSY * 5.0), 16'h0001, "early");
    run_op(op_read_array, 22'h000007, 16'h0000, 1'b0);
    check(q, 16'h1007, "array in program suspend");
    run_op(op_read_id, 22'h000000, 16'h0000, 1'b0);
    check(q, ID_W, "identifier in program suspend");
    run_op(op_resume, 22'h000007, 16'h0000, 1'b0);
    check(DQ_W'(q[STATUS_READY_BIT]), DQ_W'(1'b1), "ready after resume");
    run_op(op_read_array, 22'h000007, 16'h0000, 1'b0);
    check(q, 16'h1234, "resumed word");
    $display("test program suspend done");
  endtask : t_prog_susp

  task automatic t_erase_susp();
    run_op(op_erase, 22'h000000, 16'h0000, 1'b1);
    check(DQ_W'(sq), DQ_W'(1'b1), "erase suspended");
    run_op(op_read_array, 22'h000003, 16'h0000, 1'b0);
    check(q, 16'hA5C3, "array in erase suspend");
    run_op(op_read_status, 22'h000000, 16'h0000, 1'b0);
    check(q, 16'h0080, "status in erase suspend");
    run_op(op_resume, 22'h000000, 16'h0000, 1'b0);
    check(DQ_W'(q[STATUS_READY_BIT]), DQ_W'(1'b1), "ready after erase");
    run_op(op_read_array, 22'h000003, 16'h0000, 1'b0);
    check(q, 16'hFFFF, "erased word");
    $display("test erase suspend done");
  endtask : t_erase_susp

  task automatic t_clk_en();
    clk_en = 1'b0;
    req_op = op_read_status;
    req_valid = 1'b1;
    repeat (3) begin
      @(posedge mclk);
      #1;
      check(DQ_W'(req_ready), DQ_W'(1'b0), "frozen refuses requests");
      check(DQ_W'(ce_n), DQ_W'(1'b1), "frozen bus stays idle");
      check(DQ_W'(resp_valid), DQ_W'(1'b0), "frozen gives no response");
    end
    req_valid = 1'b0;
    clk_en = 1'b1;
    @(posedge mclk);
    #1;
    check(DQ_W'(ce_n), DQ_W'(1'b1), "no request kept from freeze");
    @(posedge mclk);
    #1;
    $display("test clock enable done");
  endtask : t_clk_en

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    req_valid = 1'b0;
    suspend_req = 1'b0;
    req_op = op_read_array;
    req_addr = '0;
    req_data = '0;
    repeat (8) @(posedge mclk);
    #1;
    check(DQ_W'(ce_n), DQ_W'(1'b1), "chip idle in reset");
    check(DQ_W'(we_n), DQ_W'(1'b1), "strobe idle in reset");
    reset = 1'b0;
    t_reads();
    t_program();
    t_prog_susp();
    t_erase_susp();
    t_clk_en();
    test_done();
  end
endmodule : tb_top
